// ===== ufi_pkg.sv
package ufi_pkg;

  // Register addresses on the host port
  localparam logic [2:0] ADDR_DATA    = 3'h0;
  localparam logic [2:0] ADDR_ENABLES = 3'h1;
  localparam logic [2:0] ADDR_IDENT   = 3'h2;
  localparam logic [2:0] ADDR_LINE    = 3'h5;
  localparam logic [2:0] ADDR_MODEM   = 3'h6;

  // Enable register bit positions
  localparam int EN_RX    = 0;
  localparam int EN_TX    = 1;
  localparam int EN_LINE  = 2;
  localparam int EN_MODEM = 3;

  // FIFO setup register fields
  localparam int FS_ENABLE  = 0;
  localparam int FS_TRIG_LO = 6;
  localparam int FS_TRIG_HI = 7;

  // Identification codes, bits 3..0
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [3:0] ID_LINE    = 4'h6;
  localparam logic [3:0] ID_RXDATA  = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hc;
  localparam logic [3:0] ID_TXEMPTY = 4'h2;
  localparam logic [3:0] ID_MODEM   = 4'h0;

  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;

  // Reset values
  localparam logic [3:0] ENABLES_RESET = 4'h0;
  localparam logic [1:0] TRIG_RESET    = 2'h0;

  // Character timing, in receiver clock ticks
  localparam int         CNT_W          = 12;
  localparam logic [3:0] BASE_BITS      = 4'h7;
  localparam int         TICK_SHIFT     = 4;
  localparam int         TIMEOUT_SHIFT  = 2;
  localparam logic [11:0] TICKS_PER_BIT = 12'h010;

  // Transmit-empty sequencing
  typedef enum logic [1:0] {
    UFI_TX_FULL,
    UFI_TX_DELAY,
    UFI_TX_IDLE
  } ufi_tx_st_t;

endpackage : ufi_pkg

// ===== ufi_irq.sv
`timescale 1ns/100ps
// Behaviour
// - FIFO mode: receive-data interrupt while fill at or above trigger level
// - Line status identity beats received-data identity
// - Data ready set on each stored character, held until FIFO empty
// - Time-out when FIFO not empty and no arrival nor read for four characters
// - Character times counted on receiver clock ticks
// - Pending time-out cleared, with its timer, by one receive read
// - Without pending time-out, arrival or read restarts the timer
// - Transmit-empty on empty FIFO, withdrawn by holding write or identity read
// - Delay transmit-empty one character less stop bit unless two bytes seen
// - First transmit-empty after FIFO enable change is immediate
// - Receive and transmit polled independently by their enables
// - Polled mode reports no trigger or time-out; FIFOs keep storing
// - Line errors recorded even with their interrupt disabled
// - Enable bits 0..3 as assigned, bits 4..7 read zero
// - Interrupt output only for enabled sources
// - Rank: line status, receive or time-out, transmit-empty, modem
// - Identity bit 0 low while anything pending
// - Identity bits 3..0 encode highest pending source
// - Identity bits 7..6 follow FIFO enable, bits 5..4 zero
// - Line errors raise line status; host clears by reading line status
// - Modem changes raise modem status; clear by modem read
// - Trigger select 00,01,10,11 gives 1,4,8,14 bytes
module ufi_irq
  import ufi_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output      logic [7:0] rdata,
  input  wire logic       divisor_access,
  input  wire logic [1:0] word_len_sel,
  input  wire logic       parity_on,
  input  wire logic       two_stop,
  input  wire logic       rclk,
  input  wire logic [4:0] rx_fill,
  input  wire logic       char_received,
  input  wire logic       line_error_event,
  input  wire logic       modem_change_event,
  input  wire logic [4:0] tx_fill,
  output      logic       interrupt_output,
  output      logic       data_ready_flag,
  output      logic       fifo_enable_control
);

  // Ticks in one character of the programmed format
  function automatic logic [CNT_W-1:0] char_ticks(
    input logic [1:0] wl,
    input logic       par,
    input logic       stp
  );
    logic [CNT_W-1:0] bits;
    bits = CNT_W'(BASE_BITS) + CNT_W'(wl) + CNT_W'(par) + CNT_W'(stp);
    return CNT_W'(bits << TICK_SHIFT);
  endfunction : char_ticks

  // Trigger level decode
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0:    return TRIG_1;
      2'h1:    return TRIG_4;
      2'h2:    return TRIG_8;
      default: return TRIG_14;
    endcase
  endfunction : trig_level

  logic [3:0]        source_enable_register;
  logic [3:0]        next_source_enable_register;
  logic              next_fifo_enable_control;
  logic [1:0]        trig_sel;
  logic [1:0]        next_trig_sel;
  logic              fifo_changed;
  logic              next_fifo_changed;
  logic [7:0]        next_rdata;
  logic              rclk_meta;
  logic              rclk_sync;
  logic              rclk_last;
  logic              tick;
  logic [CNT_W-1:0]  to_cnt;
  logic [CNT_W-1:0]  next_to_cnt;
  logic              to_pend;
  logic              next_to_pend;
  logic              line_flag;
  logic              next_line_flag;
  logic              modem_flag;
  logic              next_modem_flag;
  ufi_tx_st_t        tx_st;
  ufi_tx_st_t        next_tx_st;
  logic [CNT_W-1:0]  tx_cnt;
  logic [CNT_W-1:0]  next_tx_cnt;
  logic              seen_two;
  logic              next_seen_two;
  logic              holding_empty_pend;
  logic              next_holding_empty_pend;
  logic              next_interrupt_output;
  logic              next_data_ready_flag;
  logic [3:0]        cur_id;
  logic [7:0]        ident;
  logic              data_sel;
  logic              rx_read;
  logic              thr_write;
  logic              ident_read;
  logic              setup_write;
  logic              en_write;
  logic              rx_on;
  logic              to_on;
  logic              tx_on;
  logic              line_on;
  logic              modem_on;
  logic              tx_empty;
  logic [CNT_W-1:0]  one_char;
  logic [CNT_W-1:0]  to_limit;

  // Host strobe decode
  assign data_sel    = !divisor_access;
  assign rx_read     = rd && (addr == ADDR_DATA) && data_sel;
  assign thr_write   = wr && (addr == ADDR_DATA) && data_sel;
  assign en_write    = wr && (addr == ADDR_ENABLES) && data_sel;
  assign ident_read  = rd && (addr == ADDR_IDENT);
  assign setup_write = wr && (addr == ADDR_IDENT);

  // Character time figures
  assign one_char = char_ticks(word_len_sel, parity_on, two_stop);
  assign to_limit = CNT_W'(one_char << TIMEOUT_SHIFT);
  assign tx_empty = (tx_fill == 5'h00);

  // Gated sources; disabled enables keep a side polled
  assign rx_on    = source_enable_register[EN_RX] &&
                    (fifo_enable_control ? (rx_fill >= trig_level(trig_sel))
                                         : (rx_fill != 5'h00));
  assign to_on    = source_enable_register[EN_RX] && fifo_enable_control
                    && to_pend;
  assign tx_on    = source_enable_register[EN_TX] && holding_empty_pend;
  assign line_on  = source_enable_register[EN_LINE] && line_flag;
  assign modem_on = source_enable_register[EN_MODEM] && modem_flag;

  // Priority encode, recomputed every cycle
  always_comb begin
    if (line_on) begin
      cur_id = ID_LINE;
    end else if (rx_on) begin
      cur_id = ID_RXDATA;
    end else if (to_on) begin
      cur_id = ID_TIMEOUT;
    end else if (tx_on) begin
      cur_id = ID_TXEMPTY;
    end else if (modem_on) begin
      cur_id = ID_MODEM;
    end else begin
      cur_id = ID_NONE;
    end
  end

  // Identification byte
  assign ident = {fifo_enable_control, fifo_enable_control, 2'h0, cur_id};

  // Control registers and read data
  always_comb begin
    next_source_enable_register = source_enable_register;
    next_fifo_enable_control    = fifo_enable_control;
    next_trig_sel               = trig_sel;
    next_fifo_changed           = fifo_changed;
    next_rdata                  = 8'h00;
    if (en_write) begin
      next_source_enable_register = wdata[3:0];
    end
    if (setup_write) begin
      next_fifo_enable_control = wdata[FS_ENABLE];
      if (wdata[FS_ENABLE] != fifo_enable_control) begin
        next_fifo_changed = 1'b1;
      end
      if (wdata[FS_ENABLE]) begin
        next_trig_sel = wdata[FS_TRIG_HI:FS_TRIG_LO];
      end
    end else if (next_holding_empty_pend && !holding_empty_pend) begin
      next_fifo_changed = 1'b0;
    end
    if (rd && (addr == ADDR_ENABLES) && data_sel) begin
      next_rdata = {4'h0, source_enable_register};
    end else if (ident_read) begin
      next_rdata = ident;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      source_enable_register <= ENABLES_RESET;
      fifo_enable_control    <= 1'b0;
      trig_sel               <= TRIG_RESET;
      fifo_changed           <= 1'b0;
      rdata                  <= 8'h00;
    end else begin
      source_enable_register <= next_source_enable_register;
      fifo_enable_control    <= next_fifo_enable_control;
      trig_sel               <= next_trig_sel;
      fifo_changed           <= next_fifo_changed;
      rdata                  <= next_rdata;
    end
  end

  // Receiver clock synchroniser and tick detect
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rclk_meta <= 1'b0;
      rclk_sync <= 1'b0;
      rclk_last <= 1'b0;
    end else begin
      rclk_meta <= rclk;
      rclk_sync <= rclk_meta;
      rclk_last <= rclk_sync;
    end
  end

  assign tick = rclk_sync && !rclk_last;

  // Character time-out timer
  always_comb begin
    next_to_cnt  = to_cnt;
    next_to_pend = to_pend;
    if (to_pend) begin
      if (rx_read) begin
        next_to_pend = 1'b0;
        next_to_cnt  = '0;
      end
    end else if (rx_read || char_received) begin
      next_to_cnt = '0;
    end else if (tick && (to_cnt <= to_limit)) begin
      next_to_cnt = to_cnt + CNT_W'(1);
    end
    if (!to_pend && (to_cnt > to_limit) && (rx_fill != 5'h00)
        && fifo_enable_control && source_enable_register[EN_RX]) begin
      next_to_pend = 1'b1;
    end
    if (rx_fill == 5'h00 || !fifo_enable_control) begin
      next_to_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      to_cnt  <= '0;
      to_pend <= 1'b0;
    end else begin
      to_cnt  <= next_to_cnt;
      to_pend <= next_to_pend;
    end
  end

  // Sticky line and modem flags; a new event beats a clearing read
  always_comb begin
    next_line_flag  = line_flag;
    next_modem_flag = modem_flag;
    if (rd && (addr == ADDR_LINE)) begin
      next_line_flag = 1'b0;
    end
    if (line_error_event) begin
      next_line_flag = 1'b1;
    end
    if (rd && (addr == ADDR_MODEM)) begin
      next_modem_flag = 1'b0;
    end
    if (modem_change_event) begin
      next_modem_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      line_flag  <= 1'b0;
      modem_flag <= 1'b0;
    end else begin
      line_flag  <= next_line_flag;
      modem_flag <= next_modem_flag;
    end
  end

  // Transmit-empty sequencer
  always_comb begin
    next_tx_st     = tx_st;
    next_tx_cnt    = tx_cnt;
    next_holding_empty_pend = holding_empty_pend;
    next_seen_two  = tx_empty ? 1'b0 : (seen_two || (tx_fill >= 5'h02));
    if (thr_write || (ident_read && cur_id == ID_TXEMPTY)) begin
      next_holding_empty_pend = 1'b0;
    end
    case (tx_st)
      UFI_TX_FULL: begin
        if (tx_empty) begin
          if (seen_two || fifo_changed || !fifo_enable_control) begin
            next_holding_empty_pend = 1'b1;
            next_tx_st     = UFI_TX_IDLE;
          end else begin
            next_tx_cnt = one_char - TICKS_PER_BIT;
            next_tx_st  = UFI_TX_DELAY;
          end
        end
      end
      UFI_TX_DELAY: begin
        if (!tx_empty) begin
          next_tx_st = UFI_TX_FULL;
        end else if (fifo_changed || tx_cnt == '0) begin
          next_holding_empty_pend = 1'b1;
          next_tx_st     = UFI_TX_IDLE;
        end else if (tick) begin
          next_tx_cnt = tx_cnt - CNT_W'(1);
        end
      end
      UFI_TX_IDLE: begin
        if (!tx_empty) begin
          next_tx_st = UFI_TX_FULL;
        end else if (setup_write && wdata[FS_ENABLE] != fifo_enable_control) begin
          next_holding_empty_pend = 1'b1;
        end else if (en_write && wdata[EN_TX] && !source_enable_register[EN_TX]) begin
          next_holding_empty_pend = 1'b1;
        end
      end
      default: begin
        next_tx_st = UFI_TX_IDLE;
      end
    endcase
    if (!tx_empty) begin
      next_holding_empty_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_st     <= UFI_TX_IDLE;
      tx_cnt    <= '0;
      seen_two  <= 1'b0;
      holding_empty_pend <= 1'b0;
    end else begin
      tx_st     <= next_tx_st;
      tx_cnt    <= next_tx_cnt;
      seen_two  <= next_seen_two;
      holding_empty_pend <= next_holding_empty_pend;
    end
  end

  // Registered outputs
  assign next_interrupt_output = (cur_id != ID_NONE);
  assign next_data_ready_flag  = (rx_fill != 5'h00);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      interrupt_output <= 1'b0;
      data_ready_flag  <= 1'b0;
    end else begin
      interrupt_output <= next_interrupt_output;
      data_ready_flag  <= next_data_ready_flag;
    end
  end

endmodule : ufi_irq

// ===== ufi_irq_monitor.sv
`timescale 1ns/100ps
module ufi_irq_monitor (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [2:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       divisor_access,
  input wire logic [4:0] rx_fill,
  input wire logic       interrupt_output,
  input wire logic       data_ready_flag,
  input wire logic       fifo_enable_control
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Data ready follows the receive fill one cycle later
  a_ready_set: assert property (
    rx_fill != 5'h00 |=> data_ready_flag) else $error("data ready not set");
  a_ready_clear: assert property (
    rx_fill == 5'h00 |=> !data_ready_flag) else $error("data ready not cleared");
  // Enable register upper bits and hidden access
  a_enables_hi: assert property (
    rd && addr == 3'h1 && !divisor_access |=> rdata[7:4] == 4'h0) else $error("enable bits 7..4 set");
  a_div_hide: assert property (
    rd && addr == 3'h1 && divisor_access |=> rdata == 8'h00) else $error("enables seen when hidden");
  // Identity read-back fields
  a_ident_fixed: assert property (
    rd && addr == 3'h2 |=> rdata[5:4] == 2'b00 && rdata[7:6] == {2{$past(fifo_enable_control)}})
    else $error("identity upper bits wrong");
  a_ident_pend: assert property (
    rd && addr == 3'h2 |=> rdata[0] == !interrupt_output) else $error("pending bit disagrees");
  a_ident_code: assert property (
    rd && addr == 3'h2 |=> rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
    else $error("illegal identity code");
  a_char_mode: assert property (
    rd && addr == 3'h2 && !fifo_enable_control |=> !rdata[3]) else $error("bit 3 in char mode");
endmodule : ufi_irq_monitor

bind ufi_irq ufi_irq_monitor u_mon (.mclk, .rstn, .addr, .rd, .rdata, .divisor_access,
  .rx_fill, .interrupt_output, .data_ready_flag, .fifo_enable_control);

// ===== ufi_rx_feed.sv
`timescale 1ns/100ps
module ufi_rx_feed
  import ufi_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       push,
  input  wire logic [2:0] addr,
  input  wire logic       rd,
  input  wire logic       divisor_access,
  output      logic [4:0] rx_fill,
  output      logic       char_received,
  output      logic       rclk
);
  logic [1:0] div;

  // Free-running receiver clock, a quarter of mclk
  assign rclk = div[1];

  // Receive FIFO fill: a push stores one character, a data read removes one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div           <= 2'h0;
      rx_fill       <= 5'h00;
      char_received <= 1'b0;
    end else begin
      div           <= div + 2'h1;
      char_received <= push && rx_fill != 5'h10;
      if (push && rx_fill != 5'h10) begin
        rx_fill <= rx_fill + 5'h01;
      end else if (rd && addr == ADDR_DATA && !divisor_access && rx_fill != 5'h00) begin
        rx_fill <= rx_fill - 5'h01;
      end
    end
  end
endmodule : ufi_rx_feed

// ===== tb_uart_fifo_interrupt_logic.sv
`timescale 1ns/100ps
module tb_uart_fifo_interrupt_logic;
  logic       mclk, rstn, wr, rd, divisor_access, push, rclk;
  logic       char_received, line_error_event, modem_change_event;
  logic       interrupt_output, data_ready_flag, fifo_enable_control, fifo_on;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [4:0] rx_fill, tx_fill;
  logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  int         n_fail, compares;

  ufi_irq DUT (.mclk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .divisor_access,
    .word_len_sel(2'h0), .parity_on(1'b0), .two_stop(1'b0), .rclk, .rx_fill, .char_received,
    .line_error_event, .modem_change_event, .tx_fill, .interrupt_output, .data_ready_flag,
    .fifo_enable_control);
  ufi_rx_feed feed (.mclk, .rstn, .push, .addr, .rd, .divisor_access, .rx_fill,
    .char_received, .rclk);

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task wrap_up;
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task rd_is(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask : rd_is

  task id_is(input logic [3:0] c);
    rd_is(3'h2, {fifo_on, fifo_on, 2'b00, c});
  endtask : id_is

  task push_n(input int n);
    repeat (n) begin
      @(posedge mclk);
      push <= 1'b1;
      @(posedge mclk);
      push <= 1'b0;
    end
  endtask : push_n

  // One-cycle source event: modem change when m is set, else line error
  task pulse(input logic m);
    @(posedge mclk);
    modem_change_event <= m;
    line_error_event   <= !m;
    @(posedge mclk);
    modem_change_event <= 1'b0;
    line_error_event   <= 1'b0;
  endtask : pulse

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    wrap_up();
  end

  initial begin
    {rstn, wr, rd, divisor_access, push, line_error_event, modem_change_event} = '0;
    {addr, wdata, tx_fill, fifo_on, n_fail, compares} = '0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    id_is(4'h1);
    rd_is(3'h1, 8'h00);
    wr_reg(3'h1, 8'hff);
    rd_is(3'h1, 8'h0f);
    wr_reg(3'h1, 8'h00);
    divisor_access <= 1'b1;
    wr_reg(3'h1, 8'h0f);
    divisor_access <= 1'b0;
    rd_is(3'h1, 8'h00);
    rd_is(3'h3, 8'h00);
    // Trigger levels
    wr_reg(3'h2, 8'h01);
    fifo_on = 1'b1;
    wr_reg(3'h1, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr_reg(3'h2, {s[1:0], 5'h00, 1'b1});
      push_n(lv[s] - 5'h01);
      id_is(4'h1);
      push_n(1);
      id_is(4'h4);
      rd_reg(3'h0, d);
      id_is(4'h1);
      chk({7'h00, data_ready_flag}, {7'h00, lv[s] != 5'h01});
      repeat (lv[s] - 5'h01) rd_reg(3'h0, d);
      repeat (2) @(posedge mclk);
      chk({7'h00, data_ready_flag}, 8'h00);
    end
    // Line status against received data, then polled mode
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h1, 8'h05);
    push_n(1);
    pulse(1'b0);
    id_is(4'h6);
    chk({7'h00, interrupt_output}, 8'h01);
    rd_reg(3'h5, d);
    id_is(4'h4);
    wr_reg(3'h1, 8'h01);
    pulse(1'b0);
    id_is(4'h4);
    wr_reg(3'h1, 8'h00);
    id_is(4'h1);
    chk({7'h00, interrupt_output}, 8'h00);
    chk({7'h00, data_ready_flag}, 8'h01);
    rd_reg(3'h5, d);
    rd_reg(3'h0, d);
    // Character time-out
    wr_reg(3'h2, 8'hc1);
    wr_reg(3'h1, 8'h01);
    push_n(3);
    repeat (1000) @(posedge mclk);
    rd_reg(3'h0, d);
    repeat (1000) @(posedge mclk);
    id_is(4'h1);
    repeat (1000) @(posedge mclk);
    id_is(4'hc);
    rd_reg(3'h0, d);
    id_is(4'h1);
    rd_reg(3'h0, d);
    // Transmit-empty
    @(posedge mclk);
    tx_fill <= 5'h03;
    wr_reg(3'h1, 8'h02);
    id_is(4'h1);
    @(posedge mclk);
    tx_fill <= 5'h00;
    repeat (3) @(posedge mclk);
    id_is(4'h2);
    id_is(4'h1);
    @(posedge mclk);
    tx_fill <= 5'h01;
    repeat (3) @(posedge mclk);
    tx_fill <= 5'h00;
    repeat (10) @(posedge mclk);
    id_is(4'h1);
    repeat (500) @(posedge mclk);
    id_is(4'h2);
    // Re-arm by enabling while empty, then clear by a holding write
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h1, 8'h02);
    repeat (2) @(posedge mclk);
    chk({7'h00, interrupt_output}, 8'h01);
    wr_reg(3'h0, 8'h55);
    id_is(4'h1);
    @(posedge mclk);
    tx_fill <= 5'h01;
    wr_reg(3'h2, 8'h00);
    fifo_on = 1'b0;
    id_is(4'h1);
    chk({7'h00, fifo_enable_control}, 8'h00);
    wr_reg(3'h2, 8'h01);
    fifo_on = 1'b1;
    wr_reg(3'h1, 8'h0a);
    pulse(1'b1);
    tx_fill <= 5'h00;
    repeat (3) @(posedge mclk);
    id_is(4'h2);
    id_is(4'h0);
    chk({7'h00, interrupt_output}, 8'h01);
    rd_reg(3'h6, d);
    id_is(4'h1);
    chk({7'h00, interrupt_output}, 8'h00);
    wrap_up();
  end
endmodule : tb_uart_fifo_interrupt_logic
